/* rca_pkg.sv */
package rca_pkg;
   // register byte addresses on the apb bus
   localparam logic [7:0] ADDR_CTRL_FIRST = 8'h00;
   localparam logic [7:0] ADDR_CTRL_SECOND = 8'h04;
   localparam logic [7:0] ADDR_REF_COUNT = 8'h08;
   localparam logic [7:0] ADDR_OSC_COUNT = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;
   localparam logic [7:0] ADDR_TEST = 8'h18;
   localparam logic [7:0] ADDR_VECTOR = 8'h1c;
   // field positions
   localparam int RUN_BIT = 0;
   localparam int SEL_BIT = 1;
   localparam int MON_BIT = 0;
   localparam int REF_FLAG_BIT = 0;
   localparam int OSC_FLAG_BIT = 1;
   localparam int MODE_W = 4;
   localparam int REF_W = 17;
   localparam int OSC_W = 14;
   // counter limits
   localparam logic [16:0] REF_MAX = 17'h1387f;
   localparam logic [13:0] OSC_MAX = 14'h3fff;
   // converter interrupt vector
   localparam logic [7:0] IRQ_VECTOR = 8'h2f;
   // reset values
   localparam logic [1:0] CTRL_FIRST_RST = 2'h0;
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic [1:0] STATUS_RST = 2'h0;
   localparam logic [1:0] MASK_RST = 2'h0;
   // oscillation modes
   localparam logic [3:0] MODE_EXT_FIRST = 4'h0;
   localparam logic [3:0] MODE_REF_RES_FIRST = 4'h1;
   localparam logic [3:0] MODE_SENSOR_FIRST = 4'h2;
   localparam logic [3:0] MODE_COMBINED = 4'h3;
   localparam logic [3:0] MODE_CAP_SENSOR = 4'h4;
   localparam logic [3:0] MODE_REF_RES_SECOND = 4'h5;
   localparam logic [3:0] MODE_SENSOR_SECOND = 4'h6;
   localparam logic [3:0] MODE_EXT_SECOND = 4'h7;
   // pin indices: 0 ref res 1st, 1 sensor res 1st, 2 combined,
   // 3 ref cap 1st, 4 ref res 2nd, 5 sensor res 2nd
   localparam int PIN_N = 6;
endpackage : rca_pkg

/* rca_adc_counters.sv */
`timescale 1ns/10ps
// How it works
// - reference counter counts system clocks, wrapping after 79999.
// - oscillation counter is 14-bit binary on rc clock (external input in modes 0,7), wrapping after 16383.
// - each counter sets its own overflow flag; overflow drives the interrupt.
// - select bit 1 picks reference (0) or oscillation (1) overflow as gate.
// - interrupt vector reads as 02f hex.
// - run bit low stops oscillator pins and freezes both counters.
// - run bit high starts oscillator and counting of both clocks.
// - mode field selects first-channel resistor and capacitor paths.
// - modes 5,6 second channel; 0,7 external clock inputs; 8+ all off.
// - test bit routes the oscillation clock to the monitor pin.
// - counting starts only after the synchronized run signal rises.
// - gate overflow clears run, stops counters and raises interrupt together.
// - two oscillation channels never oscillate at the same time.
module rca_adc_counters (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rc_oscillation_clock,
   input wire logic external_clock_input_first,
   input wire logic external_clock_input_second,
   output logic reference_resistor_pin_first_o,
   output logic reference_resistor_pin_first_oe,
   output logic sensor_resistor_pin_first_o,
   output logic sensor_resistor_pin_first_oe,
   output logic combined_resistor_pin_o,
   output logic combined_resistor_pin_oe,
   output logic reference_capacitor_pin_first_o,
   output logic reference_capacitor_pin_first_oe,
   output logic reference_resistor_pin_second_o,
   output logic reference_resistor_pin_second_oe,
   output logic sensor_resistor_pin_second_o,
   output logic sensor_resistor_pin_second_oe,
   output logic oscillation_monitor_pin,
   output logic converter_interrupt_request,
   output logic [7:0] converter_interrupt_vector
);
   logic conversion_run_bit_r;
   logic interrupt_source_select_r;
   logic [3:0] oscillation_mode_field_r;
   logic [16:0] time_reference_counter_r;
   logic [13:0] oscillation_counter_r;
   logic [1:0] status_r;
   logic [1:0] status_nxt;
   logic [1:0] mask_r;
   logic monitor_en_r;
   logic count_run_sync_r;
   logic osc_prev_r;
   logic [5:0] pin_o_r;
   logic [5:0] pin_oe_r;
   logic [5:0] pin_oe_nxt;
   logic [5:0] pin_o_nxt;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic irq_r;
   logic [7:0] vector_r;
   logic mon_r;

   logic xfer_done;
   logic wr_ctrl_first;
   logic wr_ctrl_second;
   logic wr_ref;
   logic wr_osc;
   logic wr_mask;
   logic wr_test;
   logic rd_status;
   logic mapped;
   logic run_active;
   logic osc_level;
   logic osc_rise;
   logic ref_ovf;
   logic osc_ovf;
   logic gate_ovf;

   // apb: one wait state so read data can come straight from a flop
   assign xfer_done = psel && penable && pready_r;
   assign wr_ctrl_first = xfer_done && pwrite
      && paddr == rca_pkg::ADDR_CTRL_FIRST;
   assign wr_ctrl_second = xfer_done && pwrite
      && paddr == rca_pkg::ADDR_CTRL_SECOND;
   assign wr_ref = xfer_done && pwrite && paddr == rca_pkg::ADDR_REF_COUNT;
   assign wr_osc = xfer_done && pwrite && paddr == rca_pkg::ADDR_OSC_COUNT;
   assign wr_mask = xfer_done && pwrite && paddr == rca_pkg::ADDR_MASK;
   assign wr_test = xfer_done && pwrite && paddr == rca_pkg::ADDR_TEST;
   assign rd_status = xfer_done && !pwrite
      && paddr == rca_pkg::ADDR_STATUS;

   always_comb begin
      case (paddr)
         rca_pkg::ADDR_CTRL_FIRST, rca_pkg::ADDR_CTRL_SECOND,
         rca_pkg::ADDR_REF_COUNT, rca_pkg::ADDR_OSC_COUNT,
         rca_pkg::ADDR_STATUS, rca_pkg::ADDR_MASK,
         rca_pkg::ADDR_TEST, rca_pkg::ADDR_VECTOR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else if (ce) begin
         pready_r <= psel && penable && !pready_r;
         pslverr_r <= psel && penable && !pready_r && !mapped;
         if (psel && penable && !pready_r && !pwrite) begin
            case (paddr)
               rca_pkg::ADDR_CTRL_FIRST:
                  prdata_r <= {30'h0, interrupt_source_select_r,
                     conversion_run_bit_r};
               rca_pkg::ADDR_CTRL_SECOND:
                  prdata_r <= {28'h0, oscillation_mode_field_r};
               rca_pkg::ADDR_REF_COUNT:
                  prdata_r <= {15'h0, time_reference_counter_r};
               rca_pkg::ADDR_OSC_COUNT:
                  prdata_r <= {18'h0, oscillation_counter_r};
               rca_pkg::ADDR_STATUS: prdata_r <= {30'h0, status_r};
               rca_pkg::ADDR_MASK: prdata_r <= {30'h0, mask_r};
               rca_pkg::ADDR_TEST: prdata_r <= {31'h0, monitor_en_r};
               rca_pkg::ADDR_VECTOR: prdata_r <= {24'h0, vector_r};
               default: prdata_r <= 32'h0;
            endcase
         end else begin
            prdata_r <= 32'h0;
         end
      end
   end

   // count source: external inputs in modes 0 and 7, rc clock in modes 1 to 6, none in 8+
   always_comb begin
      case (oscillation_mode_field_r)
         rca_pkg::MODE_EXT_FIRST: osc_level = external_clock_input_first;
         rca_pkg::MODE_EXT_SECOND: osc_level = external_clock_input_second;
         rca_pkg::MODE_REF_RES_FIRST, rca_pkg::MODE_SENSOR_FIRST,
         rca_pkg::MODE_COMBINED, rca_pkg::MODE_CAP_SENSOR,
         rca_pkg::MODE_REF_RES_SECOND, rca_pkg::MODE_SENSOR_SECOND:
            osc_level = rc_oscillation_clock && conversion_run_bit_r;
         default: osc_level = 1'b0;
      endcase
   end

   assign run_active = conversion_run_bit_r && count_run_sync_r;
   assign osc_rise = osc_level && !osc_prev_r;
   assign ref_ovf = run_active
      && time_reference_counter_r >= rca_pkg::REF_MAX;
   assign osc_ovf = run_active && osc_rise
      && oscillation_counter_r == rca_pkg::OSC_MAX;
   assign gate_ovf = interrupt_source_select_r ? osc_ovf : ref_ovf;

   // control bits; a software write in the overflow cycle wins so a
   // restart is never swallowed
   always_ff @(posedge clk) begin
      if (srst) begin
         conversion_run_bit_r <= rca_pkg::CTRL_FIRST_RST[rca_pkg::RUN_BIT];
         interrupt_source_select_r <=
            rca_pkg::CTRL_FIRST_RST[rca_pkg::SEL_BIT];
      end else if (ce) begin
         if (wr_ctrl_first) begin
            conversion_run_bit_r <= pwdata[rca_pkg::RUN_BIT];
            interrupt_source_select_r <= pwdata[rca_pkg::SEL_BIT];
         end else if (gate_ovf) begin
            conversion_run_bit_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         oscillation_mode_field_r <= rca_pkg::MODE_RST;
         mask_r <= rca_pkg::MASK_RST;
         monitor_en_r <= 1'b0;
      end else if (ce) begin
         if (wr_ctrl_second)
            oscillation_mode_field_r <= pwdata[rca_pkg::MODE_W-1:0];
         if (wr_mask)
            mask_r <= pwdata[1:0];
         if (wr_test)
            monitor_en_r <= pwdata[rca_pkg::MON_BIT];
      end
   end

   // run sync lags the run bit one edge so both counters start together
   always_ff @(posedge clk) begin
      if (srst) begin
         count_run_sync_r <= 1'b0;
         osc_prev_r <= 1'b0;
      end else if (ce) begin
         count_run_sync_r <= conversion_run_bit_r && !gate_ovf;
         osc_prev_r <= osc_level;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         time_reference_counter_r <= 17'h0;
      end else if (ce) begin
         if (wr_ref)
            time_reference_counter_r <= pwdata[rca_pkg::REF_W-1:0];
         else if (ref_ovf)
            time_reference_counter_r <= 17'h0;
         else if (run_active)
            time_reference_counter_r <= time_reference_counter_r + 17'h1;
         // otherwise hold the result for software
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         oscillation_counter_r <= 14'h0;
      end else if (ce) begin
         if (wr_osc)
            oscillation_counter_r <= pwdata[rca_pkg::OSC_W-1:0];
         else if (run_active && osc_rise)
            oscillation_counter_r <= oscillation_counter_r + 14'h1;
      end
   end

   // sticky flags: an overflow in the read cycle survives the clear
   always_comb begin
      status_nxt = rd_status ? 2'h0 : status_r;
      status_nxt[rca_pkg::REF_FLAG_BIT] =
         status_nxt[rca_pkg::REF_FLAG_BIT] | ref_ovf;
      status_nxt[rca_pkg::OSC_FLAG_BIT] =
         status_nxt[rca_pkg::OSC_FLAG_BIT] | osc_ovf;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         status_r <= rca_pkg::STATUS_RST;
         irq_r <= 1'b0;
         vector_r <= 8'h0;
      end else if (ce) begin
         status_r <= status_nxt;
         irq_r <= |(status_nxt & mask_r);
         vector_r <= rca_pkg::IRQ_VECTOR;
      end
   end

   // pin decode; resistor pin follows the oscillation, capacitor inverted
   always_comb begin
      pin_oe_nxt = 6'h0;
      pin_o_nxt = 6'h0;
      if (conversion_run_bit_r) begin
         case (oscillation_mode_field_r)
            rca_pkg::MODE_REF_RES_FIRST: pin_oe_nxt = 6'h09;
            rca_pkg::MODE_SENSOR_FIRST: pin_oe_nxt = 6'h0a;
            rca_pkg::MODE_COMBINED: pin_oe_nxt = 6'h0c;
            rca_pkg::MODE_CAP_SENSOR: pin_oe_nxt = 6'h05;
            rca_pkg::MODE_REF_RES_SECOND: pin_oe_nxt = 6'h10;
            rca_pkg::MODE_SENSOR_SECOND: pin_oe_nxt = 6'h20;
            default: pin_oe_nxt = 6'h0;
         endcase
         pin_o_nxt = rc_oscillation_clock ? 6'h33 : 6'h0c;
         // combined pin is the resistor side in mode 3, the capacitor in 4
         if (oscillation_mode_field_r == rca_pkg::MODE_COMBINED)
            pin_o_nxt[2] = rc_oscillation_clock;
         pin_o_nxt = pin_o_nxt & pin_oe_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pin_o_r <= 6'h0;
         pin_oe_r <= 6'h0;
         mon_r <= 1'b0;
      end else if (ce) begin
         pin_o_r <= pin_o_nxt;
         pin_oe_r <= pin_oe_nxt;
         mon_r <= monitor_en_r && osc_level;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign reference_resistor_pin_first_o = pin_o_r[0];
   assign reference_resistor_pin_first_oe = pin_oe_r[0];
   assign sensor_resistor_pin_first_o = pin_o_r[1];
   assign sensor_resistor_pin_first_oe = pin_oe_r[1];
   assign combined_resistor_pin_o = pin_o_r[2];
   assign combined_resistor_pin_oe = pin_oe_r[2];
   assign reference_capacitor_pin_first_o = pin_o_r[3];
   assign reference_capacitor_pin_first_oe = pin_oe_r[3];
   assign reference_resistor_pin_second_o = pin_o_r[4];
   assign reference_resistor_pin_second_oe = pin_oe_r[4];
   assign sensor_resistor_pin_second_o = pin_o_r[5];
   assign sensor_resistor_pin_second_oe = pin_oe_r[5];
   assign oscillation_monitor_pin = mon_r;
   assign converter_interrupt_request = irq_r;
   assign converter_interrupt_vector = vector_r;

   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_start;
      ce && !conversion_run_bit_r && wr_ctrl_first && pwdata[0];
   endsequence
   sequence s_armed;
      ce && conversion_run_bit_r && !count_run_sync_r && !wr_ctrl_first;
   endsequence

   a_ref_wrap: assert property (ce && ref_ovf && !wr_ref
      |=> time_reference_counter_r == 17'h0)
      else $error("reference counter did not wrap to zero");
   a_osc_wrap: assert property (ce && osc_ovf && !wr_osc
      |=> oscillation_counter_r == 14'h0)
      else $error("oscillation counter did not wrap to zero");
   a_ref_flag: assert property (ce && ref_ovf
      |=> status_r[0])
      else $error("reference overflow flag not set");
   a_gate_stop: assert property (ce && !interrupt_source_select_r
      && ref_ovf && !wr_ctrl_first |=> !conversion_run_bit_r
      && !count_run_sync_r)
      else $error("gate overflow did not stop conversion");
   a_gate_irq: assert property (ce && gate_ovf && !rd_status
      && mask_r[interrupt_source_select_r]
      |=> converter_interrupt_request)
      else $error("gate overflow raised no interrupt");
   a_vector_val: assert property (ce |=> converter_interrupt_vector
      == 8'h2f)
      else $error("wrong interrupt vector");
   a_halt_hold: assert property (ce && !conversion_run_bit_r && !wr_ref
      |=> $stable(time_reference_counter_r))
      else $error("reference counter moved while halted");
   a_start_seq: assert property (s_start ##1 s_armed
      |=> count_run_sync_r)
      else $error("run sync did not follow run bit");
   a_run_pins: assert property (ce && conversion_run_bit_r
      && oscillation_mode_field_r == 4'h1 |=> pin_oe_r == 6'h09
      && pin_o_r[0] != pin_o_r[3])
      else $error("mode 1 pins not complementary");
   a_one_channel: assert property (!((|pin_oe_r[3:0])
      && (|pin_oe_r[5:4])))
      else $error("both channels driven");
   a_high_modes: assert property (ce && oscillation_mode_field_r[3]
      |=> pin_oe_r == 6'h0)
      else $error("pins driven in disabled mode");
   a_monitor: assert property (ce && !monitor_en_r
      |=> !oscillation_monitor_pin)
      else $error("monitor pin active without test bit");
endmodule : rca_adc_counters

/* rca_rc_network.sv */
`timescale 1ns/10ps
// rc network seen from the pins: it only oscillates while the block drives
// one of the oscillator pins, and sits low otherwise like a drained capacitor
module rca_rc_network (
   input wire logic clk,
   input wire logic srst,
   input wire logic [5:0] pin_oe,
   output logic rc_clk,
   output logic ext_first,
   output logic ext_second
);
   logic [1:0] ph_r;
   logic [2:0] fr_r;
   always_ff @(posedge clk) begin
      if (srst || pin_oe == 6'h00) begin
         ph_r <= 2'h0;
         rc_clk <= 1'b0;
      end else begin
         ph_r <= ph_r + 2'h1;
         if (ph_r[0]) rc_clk <= ~rc_clk;
      end
   end
   // external clocks run free, period of six and two system clocks
   always_ff @(posedge clk) begin
      if (srst || fr_r == 3'h5) begin
         fr_r <= 3'h0;
      end else begin
         fr_r <= fr_r + 3'h1;
      end
   end
   assign ext_first = (fr_r < 3'h3);
   assign ext_second = fr_r[0];
endmodule : rca_rc_network

/* test_rc_oscillation_adc_counters.sv */
`timescale 1ns/10ps
`define chk(a, b) begin checks_done++; if ((a) !== (b)) begin \
   miscompares++; $display("unexpected at %0t: value differs", $time); end end
module test_rc_oscillation_adc_counters;
   logic clk, srst, ce, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0] paddr, vec;
   logic [31:0] pwdata, prdata, rdv;
   logic rc_clk, ext_first, ext_second, monitor, irq;
   logic [5:0] pin_o, pin_oe;
   int miscompares = 0;
   int checks_done = 0;
   rca_adc_counters uut (.clk(clk), .srst(srst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rc_oscillation_clock(rc_clk), .external_clock_input_first(ext_first),
      .external_clock_input_second(ext_second),
      .reference_resistor_pin_first_o(pin_o[0]),
      .reference_resistor_pin_first_oe(pin_oe[0]),
      .sensor_resistor_pin_first_o(pin_o[1]),
      .sensor_resistor_pin_first_oe(pin_oe[1]),
      .combined_resistor_pin_o(pin_o[2]), .combined_resistor_pin_oe(pin_oe[2]),
      .reference_capacitor_pin_first_o(pin_o[3]),
      .reference_capacitor_pin_first_oe(pin_oe[3]),
      .reference_resistor_pin_second_o(pin_o[4]),
      .reference_resistor_pin_second_oe(pin_oe[4]),
      .sensor_resistor_pin_second_o(pin_o[5]),
      .sensor_resistor_pin_second_oe(pin_oe[5]),
      .oscillation_monitor_pin(monitor), .converter_interrupt_request(irq),
      .converter_interrupt_vector(vec));
   rca_rc_network net (.clk(clk), .srst(srst), .pin_oe(pin_oe),
      .rc_clk(rc_clk), .ext_first(ext_first), .ext_second(ext_second));
   task test_done;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         test_done();
      end
      rdv = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `chk(rdv, e)
   endtask : rdc
   task wait_irq(input int lim, output int n);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= lim) begin
         miscompares++;
         test_done();
      end
   endtask : wait_irq
   function automatic logic [5:0] oe_tab(input int m);
      case (m)
         1: return 6'h09;
         2: return 6'h0a;
         3: return 6'h0c;
         4: return 6'h05;
         5: return 6'h10;
         6: return 6'h20;
         default: return 6'h00;
      endcase
   endfunction : oe_tab
   task t_reset;
      rdc(rca_pkg::ADDR_CTRL_FIRST, 32'h0);
      rdc(rca_pkg::ADDR_CTRL_SECOND, 32'h0);
      rdc(rca_pkg::ADDR_STATUS, 32'h0);
      rdc(rca_pkg::ADDR_VECTOR, 32'h2f);
      `chk(vec, rca_pkg::IRQ_VECTOR)
      `chk(pin_oe, 6'h00)
      rdc(8'h20, 32'h0);
      `chk(rerr, 1'b1)
   endtask : t_reset
   task t_ref_gate;
      int n;
      wr(rca_pkg::ADDR_REF_COUNT, 32'h13876);
      wr(rca_pkg::ADDR_OSC_COUNT, 32'h0);
      wr(rca_pkg::ADDR_CTRL_SECOND, 32'h1);
      wr(rca_pkg::ADDR_MASK, 32'h1);
      wr(rca_pkg::ADDR_CTRL_FIRST, 32'h1);
      wait_irq(60, n);
      `chk(n >= 11 && n <= 14, 1'b1)
      rdc(rca_pkg::ADDR_CTRL_FIRST, 32'h0);
      rdc(rca_pkg::ADDR_REF_COUNT, 32'h0);
      apb(1'b0, rca_pkg::ADDR_OSC_COUNT, 32'h0);
      `chk(rdv >= 1 && rdv <= 5, 1'b1)
      rdc(rca_pkg::ADDR_STATUS, 32'h1);
      rdc(rca_pkg::ADDR_STATUS, 32'h0);
      `chk(irq, 1'b0)
   endtask : t_ref_gate
   task t_osc_gate;
      int n;
      logic [31:0] v;
      wr(rca_pkg::ADDR_OSC_COUNT, 32'h3ffc);
      wr(rca_pkg::ADDR_REF_COUNT, 32'h0);
      wr(rca_pkg::ADDR_MASK, 32'h2);
      wr(rca_pkg::ADDR_CTRL_FIRST, 32'h3);
      wait_irq(200, n);
      rdc(rca_pkg::ADDR_CTRL_FIRST, 32'h2);
      rdc(rca_pkg::ADDR_OSC_COUNT, 32'h0);
      apb(1'b0, rca_pkg::ADDR_REF_COUNT, 32'h0);
      v = rdv;
      `chk(v >= 8 && v <= 30, 1'b1)
      rdc(rca_pkg::ADDR_REF_COUNT, v);
      wr(rca_pkg::ADDR_MASK, 32'h0);
      @(posedge clk);
      #1;
      `chk(irq, 1'b0)
      wr(rca_pkg::ADDR_MASK, 32'h2);
      @(posedge clk);
      #1;
      `chk(irq, 1'b1)
      rdc(rca_pkg::ADDR_STATUS, 32'h2);
      rdc(rca_pkg::ADDR_STATUS, 32'h0);
      `chk(irq, 1'b0)
   endtask : t_osc_gate
   task t_modes;
      logic [31:0] v;
      wr(rca_pkg::ADDR_REF_COUNT, 32'h0);
      for (int m = 0; m < 10; m++) begin
         wr(rca_pkg::ADDR_CTRL_SECOND, m);
         wr(rca_pkg::ADDR_CTRL_FIRST, 32'h1);
         repeat (3) @(posedge clk);
         #1;
         `chk(pin_oe, oe_tab(m))
         if (m >= 1 && m <= 4)
            `chk(^(pin_o & pin_oe), 1'b1)
         wr(rca_pkg::ADDR_CTRL_FIRST, 32'h0);
         repeat (2) @(posedge clk);
         #1;
         `chk(pin_oe, 6'h00)
      end
      apb(1'b0, rca_pkg::ADDR_REF_COUNT, 32'h0);
      v = rdv;
      repeat (10) @(posedge clk);
      rdc(rca_pkg::ADDR_REF_COUNT, v);
   endtask : t_modes
   task t_monitor;
      int hi;
      wr(rca_pkg::ADDR_CTRL_SECOND, 32'h0);
      wr(rca_pkg::ADDR_CTRL_FIRST, 32'h1);
      wr(rca_pkg::ADDR_TEST, 32'h1);
      hi = 0;
      // twelve cycles hold exactly two external periods, whatever the delay
      repeat (12) begin
         @(posedge clk);
         #1;
         hi += (monitor === 1'b1);
      end
      `chk(hi, 6)
      wr(rca_pkg::ADDR_CTRL_SECOND, 32'h7);
      repeat (3) @(posedge clk);
      hi = 0;
      repeat (12) begin
         @(posedge clk);
         #1;
         hi += (monitor === 1'b1);
      end
      `chk(hi, 6)
      // clock enable low must freeze the monitor flop at one level
      @(posedge clk);
      ce <= 1'b0;
      hi = 0;
      repeat (12) begin
         @(posedge clk);
         #1;
         hi += (monitor === 1'b1);
      end
      @(posedge clk);
      ce <= 1'b1;
      `chk(hi == 0 || hi == 12, 1'b1)
      wr(rca_pkg::ADDR_TEST, 32'h0);
      repeat (3) @(posedge clk);
      hi = 0;
      repeat (12) begin
         @(posedge clk);
         #1;
         hi += (monitor === 1'b1);
      end
      `chk(hi, 0)
      wr(rca_pkg::ADDR_CTRL_FIRST, 32'h0);
   endtask : t_monitor
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      srst = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_ref_gate();
      t_osc_gate();
      t_modes();
      t_monitor();
      test_done();
   end
   initial begin
      #6000000;
      miscompares++;
      test_done();
   end
endmodule : test_rc_oscillation_adc_counters
